/* File: verilog/sramh_pkg.sv */
// Shared constants and types of the static memory host controller.
package sramh_pkg;
    localparam int ADDR_W       = 19;
    localparam int DATA_W       = 16;
    localparam int CNT_W        = 4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RD_NS      = 45;
    localparam int T_PWE_NS     = 35;
    localparam int T_HD_NS      = 0;
    localparam int T_HZ_NS      = 18;
    localparam logic [CNT_W-1:0] RD_CYCLES =
        CNT_W'((T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PWE_CYCLES =
        CNT_W'((T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HOLD_CYCLES =
        CNT_W'((T_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > 0 ?
               (T_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : 1);
    localparam logic [CNT_W-1:0] TURN_CYCLES =
        CNT_W'((T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0]        LANES_NONE  = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_RST    = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST     = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_LAST    = 4'h1;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_RD_WAIT = 5'h02,
        ST_WR_PULS = 5'h04,
        ST_WR_HOLD = 5'h08,
        ST_RECOVER = 5'h10
    } sramh_state_e;
endpackage : sramh_pkg

/* File: verilog/sramh_tmr_if.sv */
// Carrier between the sequencer and its phase timer.
`timescale 1ns/100ps
interface sramh_tmr_if;
    import sramh_pkg::*;
    logic             load;
    logic [CNT_W-1:0] count;
    logic             done;
    modport ctrl (output load, output count, input done);
    modport tmr  (input load, input count, output done);
endinterface : sramh_tmr_if

/* File: verilog/sramh_timer.sv */
// Phase timer: a load of N makes done high in the Nth cycle after the load.
`timescale 1ns/100ps
module sramh_timer
    import sramh_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    sramh_tmr_if.tmr  tmr
);
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= CNT_RST;
        end else if (tmr.load) begin
            cnt_reg <= tmr.count;
        end else if (cnt_reg != CNT_RST) begin
            cnt_reg <= cnt_reg - CNT_LAST;
        end
    end

    assign tmr.done = (cnt_reg == CNT_LAST);
endmodule : sramh_timer

/* File: verilog/sramh_ctrl.sv */
// Host controller that runs reads and writes on an asynchronous 16-bit memory.
// Operation
// - Host holds write data around terminating edge.
// - Host never drives while device drives.
// - Write strobe stays high during reads.
// - Address loads on the same edge as selects and lanes assert.
// - Chip selects always driven to clean levels.
`timescale 1ns/100ps
module sramh_ctrl
    import sramh_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_lanes,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic [ADDR_W-1:0]      sram_addr,
    output logic                   chip_select_low_active_n,
    output logic                   chip_select_high_active,
    output logic                   write_strobe_n,
    output logic                   output_enable_n,
    output logic                   upper_lane_enable_n,
    output logic                   lower_lane_enable_n,
    output logic [DATA_W-1:0]      data_pins_o,
    output logic                   data_pins_oe,
    input  wire logic [DATA_W-1:0] data_pins_i
);
    sramh_state_e state_reg;
    sramh_state_e state_next;
    logic         take;
    logic [1:0]   lanes_n;
    sramh_tmr_if  tmr_bus ();

    sramh_timer u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tmr      (tmr_bus.tmr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    assign take    = (state_reg == ST_IDLE) && req_valid && req_ready;
    // An empty lane mask is widened to both lanes so a write is always qualified.
    assign lanes_n = (req_lanes == 2'h0) ? 2'h0 : ~req_lanes;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = req_write ? ST_WR_PULS : ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                if (tmr_bus.done) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_WR_PULS: begin
                if (tmr_bus.done) begin
                    state_next = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                if (tmr_bus.done) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (tmr_bus.done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        tmr_bus.load  = 1'b0;
        tmr_bus.count = CNT_RST;
        case (state_reg)
            ST_IDLE: begin
                tmr_bus.load  = take;
                tmr_bus.count = req_write ? PWE_CYCLES : RD_CYCLES;
            end
            ST_WR_PULS: begin
                tmr_bus.load  = tmr_bus.done;
                tmr_bus.count = HOLD_CYCLES;
            end
            ST_RD_WAIT, ST_WR_HOLD: begin
                tmr_bus.load  = tmr_bus.done;
                tmr_bus.count = TURN_CYCLES;
            end
            default: begin
                tmr_bus.load  = 1'b0;
                tmr_bus.count = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            req_ready <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_ready <= (state_next == ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory pins.

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sram_addr <= ADDR_RST;
        end else if (take) begin
            sram_addr <= req_addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_select_low_active_n <= 1'b1;
            chip_select_high_active  <= 1'b0;
            upper_lane_enable_n      <= LANES_NONE[1];
            lower_lane_enable_n      <= LANES_NONE[0];
        end else if (take) begin
            chip_select_low_active_n <= 1'b0;
            chip_select_high_active  <= 1'b1;
            upper_lane_enable_n      <= lanes_n[1];
            lower_lane_enable_n      <= lanes_n[0];
        end else if (tmr_bus.done && (state_reg == ST_RD_WAIT || state_reg == ST_WR_HOLD)) begin
            chip_select_low_active_n <= 1'b1;
            chip_select_high_active  <= 1'b0;
            upper_lane_enable_n      <= LANES_NONE[1];
            lower_lane_enable_n      <= LANES_NONE[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_strobe_n  <= 1'b1;
            output_enable_n <= 1'b1;
        end else begin
            // Write strobe falls with the selects and rises first to end the write.
            write_strobe_n  <= !(take ? req_write
                                      : (state_reg == ST_WR_PULS && !tmr_bus.done));
            // Output enable is low only for reads, so writes never see data out.
            output_enable_n <= !(take ? !req_write
                                      : (state_reg == ST_RD_WAIT && !tmr_bus.done));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_pins_o  <= DATA_RST;
            data_pins_oe <= 1'b0;
        end else if (take && req_write) begin
            data_pins_o  <= req_wdata;
            data_pins_oe <= 1'b1;
        end else if (state_reg == ST_WR_HOLD && tmr_bus.done) begin
            data_pins_oe <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= DATA_RST;
        end else begin
            rsp_valid <= (state_reg == ST_RD_WAIT) && tmr_bus.done;
            if ((state_reg == ST_RD_WAIT) && tmr_bus.done) begin
                rsp_rdata <= data_pins_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence wr_start_s;
        $fell(write_strobe_n);
    endsequence

    sequence wr_pulse_s;
        !write_strobe_n [*4] ##1 write_strobe_n && data_pins_oe;
    endsequence

    sequence rd_window_s;
        !output_enable_n [*5] ##1 rsp_valid && output_enable_n;
    endsequence

    AST_WR_QUALIFIED: assert property (@(posedge core_clk) disable iff (!rst_n)
        !write_strobe_n |-> !chip_select_low_active_n && chip_select_high_active
            && !(upper_lane_enable_n && lower_lane_enable_n))
        else $error("write strobe low without full qualification");

    AST_WR_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_start_s |-> wr_pulse_s)
        else $error("write strobe pulse length wrong or data dropped early");

    AST_WR_DATA_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(write_strobe_n) |-> data_pins_oe && $stable(data_pins_o))
        else $error("write data not held at write end");

    AST_NO_CONTENTION: assert property (@(posedge core_clk) disable iff (!rst_n)
        data_pins_oe |-> output_enable_n && $past(output_enable_n, 2))
        else $error("host drives data while device may drive");

    AST_RD_STROBE_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        !output_enable_n |-> write_strobe_n && !data_pins_oe)
        else $error("write strobe low during a read");

    AST_ADDR_STABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !chip_select_low_active_n && !$fell(chip_select_low_active_n) |-> $stable(sram_addr))
        else $error("address moved while selected");

    AST_JOINT_DESELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(chip_select_low_active_n) |-> $fell(chip_select_high_active) && write_strobe_n)
        else $error("chip selects released apart or with strobe low");

    AST_RD_ANSWER: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && !req_write |-> ##1 rd_window_s)
        else $error("read answer not on time");

    AST_IDLE_DESELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_ready |-> chip_select_low_active_n && !chip_select_high_active && !data_pins_oe)
        else $error("memory selected while idle");
endmodule : sramh_ctrl

/* File: bench/sramh_mem_model.sv */
// Behavioural model of the asynchronous 16-bit static memory on the far side.
`timescale 1ns/100ps
module sramh_mem_model
    import sramh_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              cs_low_n,
    input  wire logic              cs_high,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic              ub_n,
    input  wire logic              lb_n,
    input  wire logic [DATA_W-1:0] din,
    output logic      [DATA_W-1:0] dout,
    output logic      [1:0]        drv
);
    logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
    logic              sel;
    logic              wr;
    logic [DATA_W-1:0] word;
    assign sel  = !cs_low_n && cs_high && !(ub_n && lb_n);
    assign wr   = sel && !we_n;
    assign word = mem[addr];
    assign drv  = (sel && we_n && !oe_n) ? {!ub_n, !lb_n} : 2'h0;
    // Undriven lanes show the inverse so a stale value never passes.
    assign dout = {drv[1] ? word[15:8] : ~word[15:8], drv[0] ? word[7:0] : ~word[7:0]};
    always @(wr or addr or din or ub_n or lb_n) begin
        if (wr) begin
            mem[addr] = {ub_n ? mem[addr][15:8] : din[15:8],
                         lb_n ? mem[addr][7:0] : din[7:0]};
        end
    end
endmodule : sramh_mem_model

/* File: bench/sramh_ctrl_test.sv */
// Self-checking testbench of the static memory host controller.
`timescale 1ns/100ps
module sramh_ctrl_test;
    import sramh_pkg::*;
    logic core_clk, rst_n, req_valid, req_write, req_ready, rsp_valid;
    logic [ADDR_W-1:0] req_addr, sram_addr, prev_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, data_pins_o, data_pins_i, dev_out, q;
    logic [1:0]        req_lanes, dev_drv;
    logic cs_n, cs, we_n, oe_n, ub_n, lb_n, data_pins_oe, prev_we, prev_cs;
    logic [DATA_W:0]   prev_dat;
    int                fails, samples_checked, cycles;
    assign data_pins_i = data_pins_oe ? data_pins_o : dev_out;
    sramh_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lanes(req_lanes), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .sram_addr(sram_addr), .chip_select_low_active_n(cs_n),
        .chip_select_high_active(cs), .write_strobe_n(we_n), .output_enable_n(oe_n),
        .upper_lane_enable_n(ub_n), .lower_lane_enable_n(lb_n), .data_pins_o(data_pins_o),
        .data_pins_oe(data_pins_oe), .data_pins_i(data_pins_i));
    sramh_mem_model mem (.addr(sram_addr), .cs_low_n(cs_n), .cs_high(cs), .we_n(we_n),
        .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .din(data_pins_o), .dout(dev_out),
        .drv(dev_drv));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : check_eq
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // Called just after an edge; returns just after the edge where ready returns.
    task automatic do_req(input logic wr, input logic [18:0] a, input logic [15:0] d,
                          input logic [1:0] ln, output logic [15:0] rd);
        int n;
        int rn;
        rn = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        req_lanes = ln;
        while (req_ready !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        n = 1;
        while (req_ready !== 1'b1 && n < 20) begin
            if (rsp_valid === 1'b1) begin
                rn = n;
                rd = rsp_rdata;
            end
            @(posedge core_clk);
            #1;
            n++;
        end
        check_eq(n, 8, "busy length");
        if (!wr) check_eq(rn, 6, "answer delay");
    endtask : do_req
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_idle();
        check_eq({cs_n, cs, data_pins_oe, req_ready}, 4'h8, "reset levels");
        rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check_eq({cs_n, cs, dev_drv}, 4'h8, "idle standby");
    endtask : test_idle
    task automatic test_full();
        do_req(1'b1, 19'h00000, 16'ha5c3, 2'h0, q);
        do_req(1'b1, 19'h7ffff, 16'h3c5a, 2'h3, q);
        do_req(1'b0, 19'h00000, 16'h0000, 2'h3, q);
        check_eq(q, 16'ha5c3, "word at bottom");
        do_req(1'b0, 19'h7ffff, 16'h0000, 2'h0, q);
        check_eq(q, 16'h3c5a, "word at top");
    endtask : test_full
    task automatic test_lanes();
        do_req(1'b1, 19'h00005, 16'h1234, 2'h3, q);
        do_req(1'b1, 19'h00005, 16'hffab, 2'h1, q);
        do_req(1'b1, 19'h00005, 16'hcdff, 2'h2, q);
        do_req(1'b0, 19'h00005, 16'h0000, 2'h3, q);
        check_eq(q, 16'hcdab, "lane writes");
        do_req(1'b0, 19'h00005, 16'h0000, 2'h1, q);
        check_eq(q[7:0], 8'hab, "low lane read");
        do_req(1'b0, 19'h00005, 16'h0000, 2'h2, q);
        check_eq(q[15:8], 8'hcd, "high lane read");
    endtask : test_lanes
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge core_clk) begin
        if (rst_n) begin
            if (!oe_n) check_eq(we_n, 1'b1, "strobe in read");
            if (!we_n) check_eq(oe_n, 1'b1, "oe in write");
            if (data_pins_oe) check_eq(dev_drv, 2'h0, "bus clash");
            if (we_n && !prev_we) check_eq({data_pins_oe, data_pins_o}, prev_dat, "hold");
            if (!cs_n && !prev_cs) check_eq(sram_addr, prev_addr, "addr moved");
        end
        prev_we   <= we_n;
        prev_cs   <= cs_n;
        prev_addr <= sram_addr;
        prev_dat  <= {data_pins_oe, data_pins_o};
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, req_valid, req_write, req_addr, req_wdata, req_lanes} = '0;
        {fails, samples_checked, cycles} = '0;
        repeat (12) @(posedge core_clk);
        #1;
        test_idle();
        test_full();
        test_lanes();
        complete_run();
    end
endmodule : sramh_ctrl_test
